// ---- src/fliv_pkg.sv ----
package fliv_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_ENABLE_PRIMARY = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_ENABLE_SECONDARY = 8'hE8;
  localparam logic [7:0] ADDR_PRIORITY_LOW_A = 8'hB8;
  localparam logic [7:0] ADDR_PRIORITY_HIGH_A = 8'hB7;
  localparam logic [7:0] ADDR_PRIORITY_LOW_B = 8'hF8;
  localparam logic [7:0] ADDR_PRIORITY_HIGH_B = 8'hF7;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int SECONDARY_USED_BITS = 4;
  localparam int PRIMARY_SRC_BITS = 7;

  // ---------------------------------------------------------------
  // Sources, numbered in polling order (index 0 is polled first).
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 11;
  localparam int SRC_EXT_PIN_ZERO = 0;
  localparam int SRC_TIMER_ZERO = 1;
  localparam int SRC_EXT_PIN_ONE = 2;
  localparam int SRC_TIMER_ONE = 3;
  localparam int SRC_COUNTER_ARRAY = 4;
  localparam int SRC_SERIAL_PORT = 5;
  localparam int SRC_TIMER_TWO = 6;
  localparam int SRC_BUS_CTRL = 7;
  localparam int SRC_CONVERTER = 8;
  localparam int SRC_BUS_TIMER_OVR = 9;
  localparam int SRC_SERIAL_PERIPH = 10;

  localparam int LEVEL_W = 2;
  localparam int NUM_LEVELS = 4;
  localparam logic [1:0] LEVEL_TOP = 2'h3;

  typedef logic [15:0] fliv_vec_t;
  localparam fliv_vec_t VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0033, 16'h0023,
    16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053
  };

endpackage : fliv_pkg

// ---- src/fliv_arbiter.sv ----
`timescale 1ns/1ps
// Picks the pending source with the highest level; ties go to the lowest index.
module fliv_arbiter #(
  parameter int N = fliv_pkg::NUM_SRC
) (
  input wire logic [N-1:0] req,
  input wire logic [2*N-1:0] level,
  output logic found,
  output logic [3:0] winner,
  output logic [1:0] win_level
);
  import fliv_pkg::*;

  always_comb begin
    found = 1'b0;
    winner = 4'h0;
    win_level = 2'h0;
    for (int i = 0; i < N; i++) begin
      // Strictly greater keeps the earlier (higher polling rank) source on a tie.
      if (req[i] && (!found || level[2*i +: 2] > win_level)) begin
        found = 1'b1;
        winner = 4'(i);
        win_level = level[2*i +: 2];
      end
    end
  end

endmodule : fliv_arbiter

// ---- src/fliv_irq_ctrl.sv ----
`timescale 1ns/1ps
module fliv_irq_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  output logic [7:0] sfr_rdata,
  input wire logic ext_pin_zero_req,
  input wire logic ext_pin_one_req,
  input wire logic timer_zero_overflow,
  input wire logic timer_one_overflow,
  input wire logic timer_two_overflow,
  input wire logic counter_array_overflow,
  input wire logic [4:0] counter_module_flag,
  input wire logic serial_rx_flag,
  input wire logic serial_tx_flag,
  input wire logic bus_tx_done,
  input wire logic bus_rx_done,
  input wire logic bus_error,
  input wire logic bus_buffer_overrun,
  input wire logic conversion_done_flag,
  input wire logic bus_timer_overrun,
  input wire logic serial_periph_req,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [1:0] active_level,
  output logic in_service
);
  import fliv_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] en_pri_q, en_pri_d;
  logic [3:0] en_sec_q, en_sec_d;
  logic [7:0] prl_a_q, prl_a_d, prh_a_q, prh_a_d;
  logic [3:0] prl_b_q, prl_b_d, prh_b_q, prh_b_d;

  function automatic logic [7:0] sfr_update(input logic [7:0] cur, input logic [7:0] addr,
                                            input logic [7:0] mine);
    logic [7:0] r;
    r = cur;
    if (addr == mine) begin
      if (sfr_wr) begin
        r = sfr_wdata;
      end else if (sfr_bit_wr) begin
        r[sfr_bit_sel] = sfr_bit_val;
      end
    end
    return r;
  endfunction : sfr_update

  always_comb begin
    logic [7:0] t;
    t = 8'h00;
    en_pri_d = sfr_update(en_pri_q, sfr_addr, ADDR_IRQ_ENABLE_PRIMARY);
    t = sfr_update({4'h0, en_sec_q}, sfr_addr, ADDR_IRQ_ENABLE_SECONDARY);
    en_sec_d = t[3:0];
    prl_a_d = sfr_update(prl_a_q, sfr_addr, ADDR_PRIORITY_LOW_A);
    prh_a_d = sfr_update(prh_a_q, sfr_addr, ADDR_PRIORITY_HIGH_A);
    t = sfr_update({4'h0, prl_b_q}, sfr_addr, ADDR_PRIORITY_LOW_B);
    prl_b_d = t[3:0];
    t = sfr_update({4'h0, prh_b_q}, sfr_addr, ADDR_PRIORITY_HIGH_B);
    prh_b_d = t[3:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_pri_q <= RESET_BYTE;
      en_sec_q <= 4'h0;
      prl_a_q <= RESET_BYTE;
      prh_a_q <= RESET_BYTE;
      prl_b_q <= 4'h0;
      prh_b_q <= 4'h0;
    end else begin
      en_pri_q <= en_pri_d;
      en_sec_q <= en_sec_d;
      prl_a_q <= prl_a_d;
      prh_a_q <= prh_a_d;
      prl_b_q <= prl_b_d;
      prh_b_q <= prh_b_d;
    end
  end

  // ---------------------------------------------------------------
  // Request gathering and gating
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] raw, en_vec, gated;
  logic [2*NUM_SRC-1:0] lvl;
  logic [7:0] ph_a, pl_a;

  always_comb begin
    raw = '0;
    raw[SRC_EXT_PIN_ZERO] = ext_pin_zero_req;
    raw[SRC_TIMER_ZERO] = timer_zero_overflow;
    raw[SRC_EXT_PIN_ONE] = ext_pin_one_req;
    raw[SRC_TIMER_ONE] = timer_one_overflow;
    raw[SRC_COUNTER_ARRAY] = counter_array_overflow | (|counter_module_flag);
    raw[SRC_SERIAL_PORT] = serial_rx_flag | serial_tx_flag;
    raw[SRC_TIMER_TWO] = timer_two_overflow;
    raw[SRC_BUS_CTRL] = bus_tx_done | bus_rx_done | bus_error | bus_buffer_overrun;
    raw[SRC_CONVERTER] = conversion_done_flag;
    raw[SRC_BUS_TIMER_OVR] = bus_timer_overrun;
    raw[SRC_SERIAL_PERIPH] = serial_periph_req;
    en_vec = '0;
    en_vec[SRC_EXT_PIN_ZERO] = en_pri_q[0];
    en_vec[SRC_TIMER_ZERO] = en_pri_q[1];
    en_vec[SRC_EXT_PIN_ONE] = en_pri_q[2];
    en_vec[SRC_TIMER_ONE] = en_pri_q[3];
    en_vec[SRC_SERIAL_PORT] = en_pri_q[4];
    en_vec[SRC_TIMER_TWO] = en_pri_q[5];
    en_vec[SRC_COUNTER_ARRAY] = en_pri_q[6];
    en_vec[SRC_BUS_CTRL] = en_sec_q[0];
    en_vec[SRC_CONVERTER] = en_sec_q[1];
    en_vec[SRC_BUS_TIMER_OVR] = en_sec_q[2];
    en_vec[SRC_SERIAL_PERIPH] = en_sec_q[3];
    gated = raw & en_vec & {NUM_SRC{en_pri_q[GLOBAL_IRQ_ENABLE_BIT]}};
    // Priority registers share the primary enable layout for the first seven sources.
    ph_a = prh_a_q;
    pl_a = prl_a_q;
    lvl = '0;
    lvl[2*SRC_EXT_PIN_ZERO +: 2] = {ph_a[0], pl_a[0]};
    lvl[2*SRC_TIMER_ZERO +: 2] = {ph_a[1], pl_a[1]};
    lvl[2*SRC_EXT_PIN_ONE +: 2] = {ph_a[2], pl_a[2]};
    lvl[2*SRC_TIMER_ONE +: 2] = {ph_a[3], pl_a[3]};
    lvl[2*SRC_SERIAL_PORT +: 2] = {ph_a[4], pl_a[4]};
    lvl[2*SRC_TIMER_TWO +: 2] = {ph_a[5], pl_a[5]};
    lvl[2*SRC_COUNTER_ARRAY +: 2] = {ph_a[6], pl_a[6]};
    lvl[2*SRC_BUS_CTRL +: 2] = {prh_b_q[0], prl_b_q[0]};
    lvl[2*SRC_CONVERTER +: 2] = {prh_b_q[1], prl_b_q[1]};
    lvl[2*SRC_BUS_TIMER_OVR +: 2] = {prh_b_q[2], prl_b_q[2]};
    lvl[2*SRC_SERIAL_PERIPH +: 2] = {prh_b_q[3], prl_b_q[3]};
  end

  logic found;
  logic [3:0] winner;
  logic [1:0] win_level;

  fliv_arbiter #(.N(NUM_SRC)) u_arb (
    .req(gated),
    .level(lvl),
    .found(found),
    .winner(winner),
    .win_level(win_level)
  );

  // ---------------------------------------------------------------
  // Nesting stack: one bit per level marks a routine in progress.
  // ---------------------------------------------------------------
  logic [NUM_LEVELS-1:0] busy_q, busy_d;
  logic req_q, req_d;
  logic [15:0] vec_q, vec_d;
  logic [1:0] plev_q, plev_d;
  logic can_preempt;

  function automatic logic [1:0] top_level(input logic [NUM_LEVELS-1:0] b);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (b[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : top_level

  always_comb begin
    // Level 3 in service blocks everything since nothing is strictly higher.
    can_preempt = (busy_q == '0) || (win_level > top_level(busy_q));
    busy_d = busy_q;
    req_d = found && can_preempt;
    vec_d = VEC_TABLE[winner];
    plev_d = win_level;
    if (irq_ack && req_q) begin
      busy_d[plev_q] = 1'b1;
    end else if (irq_return && busy_q != '0) begin
      busy_d[top_level(busy_q)] = 1'b0;
    end
    if (irq_ack) begin
      // The taken request is withdrawn until the new nesting state settles.
      req_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= '0;
      req_q <= 1'b0;
      vec_q <= 16'h0000;
      plev_q <= 2'h0;
    end else begin
      busy_q <= busy_d;
      req_q <= req_d;
      vec_q <= vec_d;
      plev_q <= plev_d;
    end
  end

  // ---------------------------------------------------------------
  // Read-back and outputs
  // ---------------------------------------------------------------
  logic [7:0] rd_q, rd_d;

  always_comb begin
    case (sfr_addr)
      ADDR_IRQ_ENABLE_PRIMARY: rd_d = en_pri_d;
      ADDR_IRQ_ENABLE_SECONDARY: rd_d = {4'h0, en_sec_d};
      ADDR_PRIORITY_LOW_A: rd_d = prl_a_d;
      ADDR_PRIORITY_HIGH_A: rd_d = prh_a_d;
      ADDR_PRIORITY_LOW_B: rd_d = {4'h0, prl_b_d};
      ADDR_PRIORITY_HIGH_B: rd_d = {4'h0, prh_b_d};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  logic [1:0] act_q;
  logic svc_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 2'h0;
      svc_q <= 1'b0;
    end else begin
      act_q <= top_level(busy_d);
      svc_q <= busy_d != '0;
    end
  end

  assign sfr_rdata = rd_q;
  assign irq_req = req_q;
  assign irq_vector = vec_q;
  assign active_level = act_q;
  assign in_service = svc_q;

endmodule : fliv_irq_ctrl

// ---- tb/fliv_irq_ctrl_monitor.sv ----
`timescale 1ns/1ps
module fliv_irq_ctrl_monitor
  import fliv_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  input wire logic bus_tx_done,
  input wire logic bus_rx_done,
  input wire logic bus_error,
  input wire logic bus_buffer_overrun,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] active_level,
  input wire logic in_service
);
  logic glob_q;
  logic glob_d;
  logic bus_any;
  assign bus_any = bus_tx_done | bus_rx_done | bus_error | bus_buffer_overrun;
  // Shadow of the global enable, since the checker cannot read the register itself.
  always_comb begin
    glob_d = glob_q;
    if (sfr_wr && sfr_addr == ADDR_IRQ_ENABLE_PRIMARY) glob_d = sfr_wdata[GLOBAL_IRQ_ENABLE_BIT];
    else if (sfr_bit_wr && sfr_addr == ADDR_IRQ_ENABLE_PRIMARY &&
             sfr_bit_sel == 3'(GLOBAL_IRQ_ENABLE_BIT))
      glob_d = sfr_bit_val;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) glob_q <= 1'b0;
    else glob_q <= glob_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_glob; !glob_q |=> !irq_req; endproperty
  a_glob: assert property (p_glob) else $error("request while blocked");
  property p_ack_drop; irq_ack |=> !irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
  property p_ack_svc; irq_ack |=> in_service; endproperty
  a_ack_svc: assert property (p_ack_svc) else $error("no service after ack");
  property p_top; in_service && active_level == LEVEL_TOP |-> !irq_req; endproperty
  a_top: assert property (p_top) else $error("top level preempted");
  property p_vec; irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0053; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_rst; $rose(rst_n) |-> !irq_req && !in_service && active_level == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_bus; irq_req && irq_vector == 16'h003B |-> $past(bus_any); endproperty
  a_bus: assert property (p_bus) else $error("bus vector without flag");
  property p_ret; $fell(in_service) |-> $past(irq_return); endproperty
  a_ret: assert property (p_ret) else $error("service ended without return");
  property p_lvl; active_level != 2'h0 |-> in_service; endproperty
  a_lvl: assert property (p_lvl) else $error("level without service");
  c_ack: cover property (irq_ack);
  c_top: cover property (active_level == LEVEL_TOP);
  c_ret: cover property (irq_return && in_service);
endmodule : fliv_irq_ctrl_monitor

bind fliv_irq_ctrl fliv_irq_ctrl_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
  .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .bus_tx_done(bus_tx_done),
  .bus_rx_done(bus_rx_done), .bus_error(bus_error), .bus_buffer_overrun(bus_buffer_overrun),
  .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
  .active_level(active_level), .in_service(in_service));

// ---- tb/fliv_core_model.sv ----
`timescale 1ns/1ps
module fliv_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ack_en,
  input wire logic irq_req,
  output logic irq_ack
);
  logic ack_d;
  // One pulse per seen request; ack_en low models a core that is busy and stalls.
  always_comb begin
    ack_d = ack_en && irq_req && !irq_ack;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_ack <= 1'b0;
    else irq_ack <= ack_d;
  end
endmodule : fliv_core_model

// ---- tb/fliv_irq_ctrl_test.sv ----
`timescale 1ns/1ps
module fliv_irq_ctrl_test;
  import fliv_pkg::*;
  logic clk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, ack_en, irq_ack, irq_return;
  logic irq_req, in_service;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0] sfr_bit_sel;
  logic [10:0] src;
  logic [3:0] alt;
  logic [4:0] cmf;
  logic [15:0] irq_vector;
  logic [1:0] active_level;
  int err_total = 0;
  int cmp_count = 0;
  logic [15:0] vec_exp [11] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0033, 16'h0023,
    16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053};
  logic [15:0] alt_exp [4] = '{16'h0023, 16'h003B, 16'h003B, 16'h003B};
  int en_idx [11] = '{0, 1, 2, 3, 5, 6, 4, 7, 8, 9, 10};

  fliv_irq_ctrl u_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
    .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .ext_pin_zero_req(src[0]),
    .timer_zero_overflow(src[1]), .ext_pin_one_req(src[2]), .timer_one_overflow(src[3]),
    .counter_array_overflow(src[4]), .serial_rx_flag(src[5]), .timer_two_overflow(src[6]),
    .bus_tx_done(src[7]), .conversion_done_flag(src[8]), .bus_timer_overrun(src[9]),
    .serial_periph_req(src[10]), .serial_tx_flag(alt[0]), .bus_rx_done(alt[1]),
    .bus_error(alt[2]), .bus_buffer_overrun(alt[3]), .counter_module_flag(cmf),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
    .active_level(active_level), .in_service(in_service));
  fliv_core_model u_core (.clk(clk), .rst_n(rst_n), .ack_en(ack_en), .irq_req(irq_req),
    .irq_ack(irq_ack));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    // An idle edge between writes keeps the strobe from toggling twice in one step.
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    cyc(1);
    chk("sfr_rdata", {8'h00, sfr_rdata}, {8'h00, e});
  endtask : rd
  // The core acks one cycle after seeing the request; the controller takes it the next.
  task automatic take();
    ack_en = 1'b1;
    cyc(2);
    ack_en = 1'b0;
  endtask : take
  task automatic ret();
    irq_return = 1'b1;
    cyc(1);
    irq_return = 1'b0;
    cyc(1);
  endtask : ret
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    {rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, ack_en, irq_return} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_sel, src, alt, cmf} = '0;
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    rd(ADDR_IRQ_ENABLE_PRIMARY, 8'h00);
    rd(8'h10, 8'h00);
    wr(ADDR_IRQ_ENABLE_PRIMARY, 8'h7F);
    wr(ADDR_IRQ_ENABLE_SECONDARY, 8'h0F);
    rd(ADDR_IRQ_ENABLE_SECONDARY, 8'h0F);
    src = 11'h7FF;
    cyc(2);
    chk("irq_req", {15'h0, irq_req}, 16'h0000);
    sfr_addr = ADDR_IRQ_ENABLE_PRIMARY;
    sfr_bit_sel = 3'h7;
    sfr_bit_val = 1'b1;
    sfr_bit_wr = 1'b1;
    cyc(1);
    sfr_bit_wr = 1'b0;
    rd(ADDR_IRQ_ENABLE_PRIMARY, 8'hFF);
    chk("irq_req", {15'h0, irq_req}, 16'h0001);
    for (i = 0; i < 11; i++) begin
      src = 11'h7FF << i;
      cyc(1);
      chk("irq_vector", irq_vector, vec_exp[i]);
    end
    src = 11'h7FF;
    for (i = 0; i < 11; i++) begin
      wr(ADDR_IRQ_ENABLE_PRIMARY, (i < 7) ? (8'h80 | (8'h01 << i)) : 8'h80);
      wr(ADDR_IRQ_ENABLE_SECONDARY, (i >= 7) ? (8'h01 << (i - 7)) : 8'h00);
      cyc(1);
      chk("irq_vector", irq_vector, vec_exp[en_idx[i]]);
    end
    wr(ADDR_IRQ_ENABLE_PRIMARY, 8'hFF);
    wr(ADDR_IRQ_ENABLE_SECONDARY, 8'h0F);
    src = 11'h000;
    for (i = 0; i < 4; i++) begin
      alt = 4'h1 << i;
      cyc(1);
      chk("irq_vector", irq_vector, alt_exp[i]);
    end
    alt = 4'h0;
    cmf = 5'h10;
    cyc(1);
    chk("irq_vector", irq_vector, 16'h0033);
    cmf = 5'h00;
    wr(ADDR_PRIORITY_LOW_A, 8'h02);
    wr(ADDR_PRIORITY_HIGH_A, 8'h04);
    wr(ADDR_PRIORITY_LOW_B, 8'h08);
    wr(ADDR_PRIORITY_HIGH_B, 8'h08);
    rd(ADDR_PRIORITY_HIGH_A, 8'h04);
    rd(ADDR_PRIORITY_LOW_B, 8'h08);
    src = 11'h003;
    cyc(1);
    chk("irq_vector", irq_vector, 16'h000B);
    take();
    chk("active_level", {14'h0, active_level}, 16'h0001);
    cyc(1);
    chk("irq_req", {15'h0, irq_req}, 16'h0000);
    src = 11'h007;
    cyc(1);
    chk("irq_vector", irq_vector, 16'h0013);
    take();
    chk("active_level", {14'h0, active_level}, 16'h0002);
    src = 11'h407;
    cyc(1);
    chk("irq_vector", irq_vector, 16'h0053);
    take();
    chk("active_level", {14'h0, active_level}, 16'h0003);
    src = 11'h7FF;
    cyc(2);
    chk("irq_req", {15'h0, irq_req}, 16'h0000);
    ret();
    chk("active_level", {14'h0, active_level}, 16'h0002);
    src = 11'h000;
    ret();
    ret();
    chk("in_service", {15'h0, in_service}, 16'h0000);
    // A reset in mid-run must clear the enables even while every source is pending.
    src = 11'h7FF;
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    rd(ADDR_IRQ_ENABLE_PRIMARY, 8'h00);
    chk("irq_req", {15'h0, irq_req}, 16'h0000);
    chk("in_service", {15'h0, in_service}, 16'h0000);
    end_of_test();
  end
endmodule : fliv_irq_ctrl_test
